// *** rtl/iru_interrupt_request_unit.v ***
// Interrupt request unit: flags, enables, edge select, stack entry/return
//
// Strobed register access and the register addresses were chosen for this implementation.
`timescale 1ns/100ps
`default_nettype none
`include "iru_defs.vh"

module iru_interrupt_request_unit
(
  input wire sys_clk,
  input wire resetn,
  input wire [7:0] src_in,
  input wire [2:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  output reg [7:0] reg_rdata,
  input wire instr_boundary,
  input wire [15:0] pc_in,
  input wire reti_strobe,
  input wire engint_strobe,
  input wire disgint_strobe,
  output reg pc_load,
  output reg [15:0] pc_value,
  output reg busy,
  output reg irq,
  output reg [7:0] mem_addr,
  output reg [7:0] mem_wdata,
  output reg mem_we,
  output reg mem_re,
  input wire [7:0] mem_rdata
);

  // ----------------------------------------------------------------
  // States
  // ----------------------------------------------------------------
  localparam [3:0] ST_IDLE = 4'b0001;
  localparam [3:0] ST_PUSH_H = 4'b0010;
  localparam [3:0] ST_POP_L = 4'b0100;
  localparam [3:0] ST_POP_D = 4'b1000;

  // Select 00 behaves as both edges, so an unset line still catches changes
  function edge_hit;
    input [1:0] sel;
    input cur;
    input prev;
    begin
      if (sel == `IRU_EDGE_RISE)
        edge_hit = cur & ~prev;
      else if (sel == `IRU_EDGE_FALL)
        edge_hit = ~cur & prev;
      else
        edge_hit = cur ^ prev;
    end
  endfunction

  reg [1:0] pin_meta_q;
  reg [1:0] pin_sync_q;
  reg [7:0] src_prev_q;
  reg [7:0] enable_q;
  reg [7:0] request_q;
  reg [15:0] edge_q;
  reg [7:0] stack_q;
  reg gie_q;
  reg [3:0] state_q;
  reg [15:0] pc_save_q;
  reg [7:0] pop_lo_q;
  reg [7:0] src_now;
  reg [7:0] event_d;
  reg [7:0] clear_d;
  reg [7:0] rdata_d;
  integer i;
  wire pending;
  wire take;
  wire ret;
  wire wr_stack;

  // ----------------------------------------------------------------
  // Source capture
  // ----------------------------------------------------------------
  // Only the two pins src_in[1:0] come from outside the clock domain
  always @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      pin_meta_q <= 2'h0;
      pin_sync_q <= 2'h0;
      src_prev_q <= 8'h00;
    end
    else
    begin
      pin_meta_q <= src_in[1:0];
      pin_sync_q <= pin_meta_q;
      src_prev_q <= src_now;
    end
  end

  always @*
  begin
    src_now = {src_in[7:2], pin_sync_q};
    event_d = 8'h00;
    clear_d = 8'h00;
    for (i = 0; i < `IRU_NUM_SRC; i = i + 1)
      event_d[i] = edge_hit(edge_q[2*i +: 2], src_now[i], src_prev_q[i]);
    if (reg_wr && reg_addr == `IRU_ADDR_REQUEST)
      clear_d = reg_wdata;
  end

  // ----------------------------------------------------------------
  // Register file
  // ----------------------------------------------------------------
  assign wr_stack = reg_wr && reg_addr == `IRU_ADDR_STACK;

  always @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      enable_q <= `IRU_RST_ENABLE;
      request_q <= `IRU_RST_REQUEST;
      edge_q <= `IRU_RST_EDGE;
    end
    else
    begin
      if (reg_wr && reg_addr == `IRU_ADDR_ENABLE)
        enable_q <= reg_wdata;
      if (reg_wr && reg_addr == `IRU_ADDR_EDGE_LO)
        edge_q[7:0] <= reg_wdata;
      if (reg_wr && reg_addr == `IRU_ADDR_EDGE_HI)
        edge_q[15:8] <= reg_wdata;
      // Set wins over a clear in the same cycle; enable plays no part here
      request_q <= (request_q & ~clear_d) | event_d;
    end
  end

  always @*
  begin
    rdata_d = 8'h00;
    case (reg_addr)
      `IRU_ADDR_ENABLE:
        rdata_d = enable_q;
      `IRU_ADDR_REQUEST:
        rdata_d = request_q;
      `IRU_ADDR_EDGE_LO:
        rdata_d = edge_q[7:0];
      `IRU_ADDR_EDGE_HI:
        rdata_d = edge_q[15:8];
      `IRU_ADDR_STACK:
        rdata_d = stack_q;
      `IRU_ADDR_STATUS:
        rdata_d = {6'h00, state_q != ST_IDLE, gie_q};
      default:
        rdata_d = 8'h00;
    endcase
  end

  always @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
      reg_rdata <= 8'h00;
    else if (reg_rd)
      reg_rdata <= rdata_d;
    else
      reg_rdata <= 8'h00;
  end

  // ----------------------------------------------------------------
  // Entry and return sequencer
  // ----------------------------------------------------------------
  assign pending = |(request_q & enable_q);
  assign take = state_q == ST_IDLE && instr_boundary && gie_q &&
    pending;
  assign ret = state_q == ST_IDLE && reti_strobe && !take;

  always @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      state_q <= ST_IDLE;
      gie_q <= 1'b0;
      stack_q <= `IRU_RST_STACK;
      pc_save_q <= 16'h0000;
      pop_lo_q <= 8'h00;
      pc_load <= 1'b0;
      pc_value <= 16'h0000;
      busy <= 1'b0;
      irq <= 1'b0;
      mem_addr <= 8'h00;
      mem_wdata <= 8'h00;
      mem_we <= 1'b0;
      mem_re <= 1'b0;
    end
    else
    begin
      pc_load <= 1'b0;
      mem_we <= 1'b0;
      mem_re <= 1'b0;
      irq <= gie_q & pending;
      if (engint_strobe)
        gie_q <= 1'b1;
      else if (disgint_strobe)
        gie_q <= 1'b0;
      if (wr_stack)
        stack_q <= reg_wdata;
      case (state_q)
        ST_IDLE:
        begin
          busy <= 1'b0;
          if (take)
          begin
            // Low byte first at the stack pointer, high byte above it
            pc_save_q <= pc_in;
            mem_we <= 1'b1;
            mem_addr <= stack_q;
            mem_wdata <= pc_in[7:0];
            gie_q <= 1'b0;
            busy <= 1'b1;
            state_q <= ST_PUSH_H;
          end
          else if (ret)
          begin
            mem_re <= 1'b1;
            mem_addr <= stack_q - `IRU_STACK_STEP;
            busy <= 1'b1;
            state_q <= ST_POP_L;
          end
        end
        ST_PUSH_H:
        begin
          mem_we <= 1'b1;
          mem_addr <= stack_q + 8'h01;
          mem_wdata <= pc_save_q[15:8];
          // A software write in this cycle loses to the hardware update
          stack_q <= stack_q + `IRU_STACK_STEP;
          pc_load <= 1'b1;
          pc_value <= `IRU_VECTOR;
          state_q <= ST_IDLE;
        end
        ST_POP_L:
        begin
          // Low byte stands on the memory read port in this cycle
          pop_lo_q <= mem_rdata;
          mem_re <= 1'b1;
          mem_addr <= stack_q - 8'h01;
          state_q <= ST_POP_D;
        end
        ST_POP_D:
        begin
          pc_load <= 1'b1;
          pc_value <= {mem_rdata, pop_lo_q};
          stack_q <= stack_q - `IRU_STACK_STEP;
          gie_q <= 1'b1;
          state_q <= ST_IDLE;
        end
        default:
          state_q <= ST_IDLE;
      endcase
    end
  end

endmodule

`default_nettype wire

// *** rtl/iru_defs.vh ***
// Constants for the interrupt request unit
`ifndef IRU_DEFS_VH
`define IRU_DEFS_VH
`define IRU_NUM_SRC 8
`define IRU_ADDR_ENABLE 3'h0
`define IRU_ADDR_REQUEST 3'h1
`define IRU_ADDR_EDGE_LO 3'h2
`define IRU_ADDR_EDGE_HI 3'h3
`define IRU_ADDR_STACK 3'h4
`define IRU_ADDR_STATUS 3'h5
`define IRU_RST_ENABLE 8'h00
`define IRU_RST_REQUEST 8'h00
`define IRU_RST_EDGE 16'h0000
`define IRU_RST_STACK 8'h00
`define IRU_VECTOR 16'h0010
`define IRU_EDGE_RISE 2'h1
`define IRU_EDGE_FALL 2'h2
`define IRU_STACK_STEP 8'h02
`define IRU_STAT_GIE 0
`define IRU_STAT_BUSY 1
`endif

// *** verification/iru_properties.sv ***
// Port-level assertion checker for the interrupt request unit
`timescale 1ns/100ps
`default_nettype none
module iru_properties (
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic instr_boundary,
  input wire logic reti_strobe,
  input wire logic engint_strobe,
  input wire logic disgint_strobe,
  input wire logic pc_load,
  input wire logic [15:0] pc_value,
  input wire logic busy,
  input wire logic irq,
  input wire logic mem_we,
  input wire logic mem_re
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!resetn);
  // Bench raises the event before enabling; irq shows two edges later
  sequence s_take;
    engint_strobe ##2 irq;
  endsequence
  property p_entry_wr;
    s_take |-> ##[0:4] mem_we;
  endproperty
  a_entry_wr: assert property (p_entry_wr) else $error("no stack write");
  property p_entry_vec;
    s_take |-> ##[0:8] (pc_load && pc_value == 16'h0010);
  endproperty
  a_entry_vec: assert property (p_entry_vec) else $error("no vector");
  property p_reti_rd;
    reti_strobe && !busy |-> ##[0:4] mem_re;
  endproperty
  a_reti_rd: assert property (p_reti_rd) else $error("no stack read");
  property p_reti_load;
    reti_strobe && !busy |-> ##[1:8] pc_load;
  endproperty
  a_reti_load: assert property (p_reti_load) else $error("no resume");
  property p_load_busy;
    $rose(pc_load) |-> busy || $past(busy);
  endproperty
  a_load_busy: assert property (p_load_busy) else $error("stray load");
  property p_dis;
    disgint_strobe && !busy |=> !mem_we [*4];
  endproperty
  a_dis: assert property (p_dis) else $error("entry when off");
  property p_once;
    pc_load && pc_value == 16'h0010 |=> !mem_we [*4];
  endproperty
  a_once: assert property (p_once) else $error("nested entry");
  property p_excl;
    !(mem_we && mem_re);
  endproperty
  a_excl: assert property (p_excl) else $error("read and write");
  c_take: cover property (s_take);
  c_reti: cover property (reti_strobe && !busy);
  c_dis: cover property (disgint_strobe && irq);
endmodule
`default_nettype wire

// *** verification/iru_cpu_model.sv ***
// Core and data memory model facing the interrupt request unit
`timescale 1ns/100ps
`default_nettype none
module iru_cpu_model #(parameter logic [15:0] START = 16'h1234) (
  input wire logic sys_clk,
  input wire logic busy,
  input wire logic pc_load,
  input wire logic [15:0] pc_value,
  input wire logic [7:0] mem_addr,
  input wire logic [7:0] mem_wdata,
  input wire logic mem_we,
  input wire logic mem_re,
  output wire logic instr_boundary,
  output var logic [15:0] pc_in,
  output wire logic [7:0] mem_rdata
);
  logic [7:0] mem_q [0:255];
  initial pc_in = START;
  assign instr_boundary = !busy;
  // Unread memory shows the inverse so a stale value never matches
  assign mem_rdata = mem_re ? mem_q[mem_addr] : ~mem_q[mem_addr];
  always @(posedge sys_clk)
  begin
    if (mem_we)
      mem_q[mem_addr] <= mem_wdata;
    if (pc_load)
      pc_in <= pc_value;
  end
endmodule
`default_nettype wire

// *** verification/test_interrupt_request_unit.sv ***
// Self-checking bench for the interrupt request unit
`include "iru_defs.vh"
`timescale 1ns/100ps
`default_nettype none
module test_interrupt_request_unit;
  logic sys_clk = 0, resetn = 0, reg_wr = 0, reg_rd = 0, got;
  logic reti_strobe = 0, engint_strobe = 0, disgint_strobe = 0;
  logic [7:0] src_in = 0, reg_wdata = 0, v;
  logic [2:0] reg_addr = 0;
  logic [15:0] pv;
  wire logic [7:0] reg_rdata, mem_addr, mem_wdata, mem_rdata;
  wire logic [15:0] pc_in, pc_value;
  wire logic instr_boundary, pc_load, busy, irq, mem_we, mem_re;
  int miscompares = 0, check_count = 0, cyc = 0, i, r;
  logic [3:0] rows [0:2] = '{4'h6, 4'h9, 4'hF};
  iru_interrupt_request_unit DUT (.sys_clk, .resetn, .src_in, .reg_addr,
    .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .instr_boundary, .pc_in,
    .reti_strobe, .engint_strobe, .disgint_strobe, .pc_load, .pc_value,
    .busy, .irq, .mem_addr, .mem_wdata, .mem_we, .mem_re, .mem_rdata);
  iru_cpu_model u_cpu (.sys_clk, .busy, .pc_load, .pc_value, .mem_addr,
    .mem_wdata, .mem_we, .mem_re, .instr_boundary, .pc_in, .mem_rdata);
  initial
  begin
    forever #5 sys_clk = ~sys_clk;
  end
  task complete_run;
    if (miscompares == 0 && check_count > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  always @(posedge sys_clk)
  begin
    cyc++;
    if (cyc == 5000)
    begin
      miscompares++;
      complete_run;
    end
  end
  task chk(input string n, input logic [15:0] seen, input logic [15:0] e);
    check_count++;
    if (seen !== e)
    begin
      miscompares++;
      $display("FAIL %s expected %h seen %h", n, e, seen);
    end
  endtask
  task wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask
  task rd(input logic [2:0] a);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1 v = reg_rdata;
  endtask
  task ins(input logic [2:0] k);
    @(posedge sys_clk);
    {reti_strobe, engint_strobe, disgint_strobe} <= k;
    @(posedge sys_clk);
    {reti_strobe, engint_strobe, disgint_strobe} <= 3'h0;
  endtask
  task ev(input int s, input logic b);
    @(posedge sys_clk);
    src_in[s] <= b;
    repeat (4) @(posedge sys_clk);
  endtask
  task wl;
    got = 1'b0;
    repeat (20)
    begin
      @(negedge sys_clk);
      if (pc_load === 1'b1 && !got)
      begin
        got = 1'b1;
        pv = pc_value;
      end
    end
  endtask
  initial
  begin
    repeat (4) @(posedge sys_clk);
    resetn <= 1'b1;
    for (r = 0; r < 8; r++)
    begin
      rd(r[2:0]);
      chk("reset value", v, 16'h0000);
    end
    for (r = 0; r < 3; r++)
    begin
      wr(`IRU_ADDR_EDGE_LO, {4{rows[r][3:2]}});
      wr(`IRU_ADDR_EDGE_HI, {4{rows[r][3:2]}});
      for (i = 0; i < 8; i++)
      begin
        wr(`IRU_ADDR_REQUEST, 8'hFF);
        ev(i, 1'b1);
        rd(`IRU_ADDR_REQUEST);
        chk("rise flag", v, 8'(rows[r][1]) << i);
        chk("masked irq", irq, 1'b0);
        wr(`IRU_ADDR_REQUEST, 8'hFF);
        ev(i, 1'b0);
        rd(`IRU_ADDR_REQUEST);
        chk("fall flag", v, 8'(rows[r][0]) << i);
      end
    end
    wr(`IRU_ADDR_EDGE_LO, 8'h55);
    wr(`IRU_ADDR_REQUEST, 8'hFF);
    wr(`IRU_ADDR_STACK, 8'h00);
    wr(`IRU_ADDR_ENABLE, 8'h04);
    ev(2, 1'b1);
    chk("gated irq", irq, 1'b0);
    ins(3'b010);
    wl;
    chk("vector", pv, `IRU_VECTOR);
    chk("saved pc", {u_cpu.mem_q[1], u_cpu.mem_q[0]}, 16'h1234);
    rd(`IRU_ADDR_STACK);
    chk("stack up", v, 16'h0002);
    rd(`IRU_ADDR_STATUS);
    chk("gie off", v[`IRU_STAT_GIE], 1'b0);
    rd(`IRU_ADDR_REQUEST);
    chk("source", v, 16'h0004);
    wr(`IRU_ADDR_REQUEST, 8'h04);
    rd(`IRU_ADDR_REQUEST);
    chk("cleared", v, 16'h0000);
    ins(3'b100);
    wl;
    chk("resume", pv, 16'h1234);
    rd(`IRU_ADDR_STACK);
    chk("stack down", v, 16'h0000);
    rd(`IRU_ADDR_STATUS);
    chk("gie on", v[`IRU_STAT_GIE], 1'b1);
    ins(3'b001);
    ev(2, 1'b0);
    ev(2, 1'b1);
    wl;
    chk("held off", got, 1'b0);
    complete_run;
  end
endmodule
bind iru_interrupt_request_unit iru_properties u_props (.sys_clk, .resetn,
  .instr_boundary, .reti_strobe, .engint_strobe, .disgint_strobe, .pc_load,
  .pc_value, .busy, .irq, .mem_we, .mem_re);
`default_nettype wire
